// ---- common/ssa_cfg.svh ----
// Constants of the synchronous serial adapter: register selects, field positions, reset values.
// Assumes inclusion by bare name from the package and the ssa_link and ssa_top modules.
// Summary of operation
// - A rising carrier-detect input is latched into status and may raise interrupt.
// - Latched carrier loss stops the receiver; receive FIFO and byte-available flag keep working.
// - A rising clear-to-send input is latched, may interrupt, and inhibits the transmitter.
// - In external sync mode that latched edge leaves transmit-slot-available unaffected.
// - Status bits: irq, parity, overrun, underflow, cts, dcd, tx slot, rx byte.
// - Address 0 write loads primary control: select, interrupt enables, control bits.
// - Control bits 3..0: clear sync, sync_char_strip, transmitter reset, receiver reset.
// - Read at address 1 gives oldest receive byte; address 0 gives status.
// - Address 1 writes go to control 2, control 3, sync code or transmit FIFO.
// - Reset input sets the receiver-reset and transmitter-reset control bits.
// - Receive and transmit paths each buffer bytes in a three-byte FIFO.
`ifndef SSA_CFG_SVH
`define SSA_CFG_SVH
`define SSA_ADDR_STAT  1'b0
`define SSA_ADDR_DATA  1'b1
`define SSA_SEL_C2     2'h0
`define SSA_SEL_C3     2'h1
`define SSA_SEL_SYNC   2'h2
`define SSA_SEL_TXF    2'h3
`define SSA_C1_RESET   8'h03
`define SSA_C1_RXRS    0
`define SSA_C1_TXRS    1
`define SSA_C1_STRIP   2
`define SSA_C1_CLRSYNC 3
`define SSA_C1_TIE     4
`define SSA_C1_RIE     5
`define SSA_C3_EXTSYNC 0
`define SSA_C3_CLRCTS  2
`define SSA_C3_CLRTUF  3
`define SSA_FIFO_DEPTH 3
`define SSA_BYTE_W     8
`define SSA_LAST_BIT   3'h7
`define SSA_ZERO8      8'h00
`endif

// ---- common/ssa_pkg.sv ----
// Types shared by the serial adapter modules.
// Assumes ssa_cfg.svh is on the include path.
`include "ssa_cfg.svh"
package ssa_pkg;
   typedef struct packed {
      logic       rw;
      logic       addr;
      logic [7:0] wdata;
   } ssa_bus_req_t;
   typedef enum logic [1:0] {
      SSA_HUNT = 2'b01,
      SSA_SYNC = 2'b10
   } ssa_rx_state_t;
endpackage : ssa_pkg

// ---- src/ssa_fifo.sv ----
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes both sides share one clock; flush empties it at once.
`timescale 1ns/1ps
`default_nettype none
module ssa_fifo
   import ssa_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 3
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             flush_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [CW-1:0]    cnt_reg;
   logic             push;
   logic             pop;
   function automatic logic [AW-1:0] f_inc(input logic [AW-1:0] p);
      f_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : f_inc
   assign in_ready_out  = (cnt_reg != CW'(DEPTH));
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out  = mem_reg[rd_reg];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_ready_in && out_valid_out;
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_reg[wr_reg] <= in_data_in;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else if (flush_in)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_reg <= f_inc(wr_reg);
         end
         if (pop)
         begin
            rd_reg <= f_inc(rd_reg);
         end
         cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
      end
   end
endmodule : ssa_fifo
`default_nettype wire

// ---- src/ssa_link.sv ----
// Link-side logic: bit capture on the receive bit clock, byte shifter on the transmit bit clock.
// Assumes bit clocks from the modem; every event hand-over to the system clock is a toggle, and the received bit crosses as a level.
`timescale 1ns/1ps
`default_nettype none
`include "ssa_cfg.svh"
module ssa_link
   import ssa_pkg::*;
(
   input  wire logic       rx_bit_clock_in,
   input  wire logic       tx_bit_clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       serial_in,
   output logic            serial_out,
   output logic            rx_bit_out,
   output logic            rx_tgl_out,
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       tx_ld_tgl_in,
   input  wire logic       tx_en_in,
   output logic            tx_ack_tgl_out,
   output logic            tx_uf_tgl_out
);
   logic [1:0] ld_s_reg;
   logic [1:0] en_s_reg;
   logic       seen_reg;
   logic [7:0] sh_reg;
   logic [2:0] n_reg;
   always_ff @(posedge rx_bit_clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_bit_out <= 1'b0;
      end
      else
      begin
         rx_bit_out <= serial_in;
      end
   end
   // The toggle moves half a bit later, so the bit is settled long before the system side sees it.
   always_ff @(negedge rx_bit_clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_tgl_out <= 1'b0;
      end
      else
      begin
         rx_tgl_out <= ~rx_tgl_out;
      end
   end
   always_ff @(posedge tx_bit_clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ld_s_reg <= 2'h0;
         en_s_reg <= 2'h0;
      end
      else
      begin
         ld_s_reg <= {ld_s_reg[0], tx_ld_tgl_in};
         en_s_reg <= {en_s_reg[0], tx_en_in};
      end
   end
   always_ff @(posedge tx_bit_clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         seen_reg       <= 1'b0;
         sh_reg         <= 8'hff;
         n_reg          <= 3'h0;
         serial_out     <= 1'b1;
         tx_ack_tgl_out <= 1'b0;
         tx_uf_tgl_out  <= 1'b0;
      end
      else if (n_reg != 3'h0)
      begin
         sh_reg     <= {1'b1, sh_reg[7:1]};
         serial_out <= sh_reg[1];
         n_reg      <= n_reg - 3'h1;
      end
      else if (ld_s_reg[1] != seen_reg)
      begin
         sh_reg         <= tx_byte_in;
         serial_out     <= tx_byte_in[0];
         n_reg          <= `SSA_LAST_BIT;
         seen_reg       <= ld_s_reg[1];
         tx_ack_tgl_out <= ~tx_ack_tgl_out;
      end
      else
      begin
         // An idle line is held at mark; underflow is reported only while enabled.
         serial_out <= 1'b1;
         if (en_s_reg[1])
         begin
            tx_uf_tgl_out <= ~tx_uf_tgl_out;
         end
      end
   end
endmodule : ssa_link
`default_nettype wire

// ---- src/ssa_top.sv ----
// Synchronous serial adapter top: bus registers, status flags, receive framing, transmit feed.
// Assumes a one-cycle chip-select strobe per bus access and modem bit clocks unrelated to mclk_in.
`timescale 1ns/1ps
`default_nettype none
`include "ssa_cfg.svh"
module ssa_top
   import ssa_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       cs_in,
   input  wire logic       rw_in,
   input  wire logic       addr_in,
   input  wire logic [7:0] wdata_in,
   output logic [7:0]      rdata_out,
   output logic            irq_out,
   input  wire logic       rx_bit_clock_in,
   input  wire logic       tx_bit_clock_in,
   input  wire logic       serial_in,
   output logic            serial_out,
   input  wire logic       dcd_in,
   input  wire logic       cts_in
);
   ssa_bus_req_t  req;
   ssa_rx_state_t st_reg;
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   logic [7:0] c3_reg;
   logic [7:0] sync_reg;
   logic [2:0] dcd_s_reg;
   logic [2:0] cts_s_reg;
   logic [1:0] bit_s_reg;
   logic [2:0] rtg_s_reg;
   logic [2:0] ack_s_reg;
   logic [2:0] uf_s_reg;
   logic       dcd_flag_reg;
   logic       cts_flag_reg;
   logic       tuf_reg;
   logic       ovrn_reg;
   logic [7:0] win_reg;
   logic [2:0] cnt_reg;
   logic       ld_pend_reg;
   logic       ld_tgl_reg;
   logic [7:0] hold_reg;
   logic [7:0] win_next;
   logic [7:0] stat;
   logic       wr0, wr1, rd0, rd1;
   logic       dcd_rise, cts_rise, bit_evt, ack_evt, uf_evt;
   logic       rx_run, tx_en, rx_push, rx_ready, rx_byte_available, rx_pop;
   logic       tx_push, tx_ready, tx_valid, ld_start, tx_slot_available, match;
   logic [7:0] rx_head;
   logic [7:0] tx_head;
   logic       rx_tgl;
   logic       rx_bit;
   logic       ack_tgl;
   logic       uf_tgl;

   function automatic logic f_is_sync(input logic [7:0] b, input logic [7:0] code);
      f_is_sync = (b == code);
   endfunction : f_is_sync

   assign req      = '{rw: rw_in, addr: addr_in, wdata: wdata_in};
   assign wr0      = cs_in && !req.rw && (req.addr == `SSA_ADDR_STAT);
   assign wr1      = cs_in && !req.rw && (req.addr == `SSA_ADDR_DATA);
   assign rd0      = cs_in && req.rw && (req.addr == `SSA_ADDR_STAT);
   assign rd1      = cs_in && req.rw && (req.addr == `SSA_ADDR_DATA);
   assign dcd_rise = dcd_s_reg[1] && !dcd_s_reg[2];
   assign cts_rise = cts_s_reg[1] && !cts_s_reg[2];
   assign bit_evt  = rtg_s_reg[1] ^ rtg_s_reg[2];
   assign ack_evt  = ack_s_reg[1] ^ ack_s_reg[2];
   assign uf_evt   = uf_s_reg[1] ^ uf_s_reg[2];
   assign rx_run   = !c1_reg[`SSA_C1_RXRS] && !dcd_flag_reg;
   assign tx_en    = !c1_reg[`SSA_C1_TXRS] && !cts_flag_reg;
   assign win_next = {bit_s_reg[1], win_reg[7:1]};
   assign match    = f_is_sync(win_next, sync_reg);
   assign rx_push  = bit_evt && rx_run && (st_reg == SSA_SYNC) && (cnt_reg == `SSA_LAST_BIT)
                     && !(c1_reg[`SSA_C1_STRIP] && match);
   assign rx_pop   = rd1 && rx_byte_available;
   assign tx_push  = wr1 && (c1_reg[7:6] == `SSA_SEL_TXF);
   assign ld_start = !ld_pend_reg && tx_valid && tx_en;
   // Without external sync the slot flag drops while clear-to-send is latched.
   assign tx_slot_available     = tx_ready && !c1_reg[`SSA_C1_TXRS]
                     && (!cts_flag_reg || c3_reg[`SSA_C3_EXTSYNC]);
   // Parity is not checked on this path, so its bit reads zero.
   assign stat     = {irq_out, 1'b0, ovrn_reg, tuf_reg, cts_flag_reg, dcd_flag_reg, tx_slot_available, rx_byte_available};

   ssa_fifo #(.WIDTH(`SSA_BYTE_W), .DEPTH(`SSA_FIFO_DEPTH)) u_rx_fifo (
      .clk_in        (mclk_in),
      .rst_n_in      (rst_n_in),
      .flush_in      (c1_reg[`SSA_C1_RXRS]),
      .in_valid_in   (rx_push),
      .in_ready_out  (rx_ready),
      .in_data_in    (win_next),
      .out_valid_out (rx_byte_available),
      .out_ready_in  (rx_pop),
      .out_data_out  (rx_head)
   );
   ssa_fifo #(.WIDTH(`SSA_BYTE_W), .DEPTH(`SSA_FIFO_DEPTH)) u_tx_fifo (
      .clk_in        (mclk_in),
      .rst_n_in      (rst_n_in),
      .flush_in      (c1_reg[`SSA_C1_TXRS]),
      .in_valid_in   (tx_push),
      .in_ready_out  (tx_ready),
      .in_data_in    (req.wdata),
      .out_valid_out (tx_valid),
      .out_ready_in  (ld_start),
      .out_data_out  (tx_head)
   );
   ssa_link u_link (
      .rx_bit_clock_in (rx_bit_clock_in),
      .tx_bit_clock_in (tx_bit_clock_in),
      .rst_n_in        (rst_n_in),
      .serial_in       (serial_in),
      .serial_out      (serial_out),
      .rx_bit_out      (rx_bit),
      .rx_tgl_out      (rx_tgl),
      .tx_byte_in      (hold_reg),
      .tx_ld_tgl_in    (ld_tgl_reg),
      .tx_en_in        (tx_en),
      .tx_ack_tgl_out  (ack_tgl),
      .tx_uf_tgl_out   (uf_tgl)
   );

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dcd_s_reg <= 3'h0;
         cts_s_reg <= 3'h0;
         bit_s_reg <= 2'h0;
         rtg_s_reg <= 3'h0;
         ack_s_reg <= 3'h0;
         uf_s_reg  <= 3'h0;
      end
      else
      begin
         dcd_s_reg <= {dcd_s_reg[1:0], dcd_in};
         cts_s_reg <= {cts_s_reg[1:0], cts_in};
         bit_s_reg <= {bit_s_reg[0], rx_bit};
         rtg_s_reg <= {rtg_s_reg[1:0], rx_tgl};
         ack_s_reg <= {ack_s_reg[1:0], ack_tgl};
         uf_s_reg  <= {uf_s_reg[1:0], uf_tgl};
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         c1_reg   <= `SSA_C1_RESET;
         c2_reg   <= `SSA_ZERO8;
         c3_reg   <= `SSA_ZERO8;
         sync_reg <= `SSA_ZERO8;
      end
      else if (wr0)
      begin
         c1_reg <= req.wdata;
      end
      else if (wr1)
      begin
         case (c1_reg[7:6])
            `SSA_SEL_C2:   c2_reg   <= req.wdata;
            `SSA_SEL_C3:   c3_reg   <= req.wdata;
            `SSA_SEL_SYNC: sync_reg <= req.wdata;
            default:       c2_reg   <= c2_reg;
         endcase
      end
   end

   // Every flag below lets a new event win over a clear in the same cycle.
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dcd_flag_reg <= 1'b0;
         cts_flag_reg <= 1'b0;
         tuf_reg      <= 1'b0;
         ovrn_reg     <= 1'b0;
      end
      else
      begin
         if (dcd_rise)
            dcd_flag_reg <= 1'b1;
         else if (c1_reg[`SSA_C1_RXRS])
            dcd_flag_reg <= 1'b0;
         if (cts_rise)
            cts_flag_reg <= 1'b1;
         else if (c1_reg[`SSA_C1_TXRS] || (wr1 && (c1_reg[7:6] == `SSA_SEL_C3) && req.wdata[`SSA_C3_CLRCTS]))
            cts_flag_reg <= 1'b0;
         if (uf_evt && tx_en)
            tuf_reg <= 1'b1;
         else if (c1_reg[`SSA_C1_TXRS] || (wr1 && (c1_reg[7:6] == `SSA_SEL_C3) && req.wdata[`SSA_C3_CLRTUF]))
            tuf_reg <= 1'b0;
         if (rx_push && !rx_ready)
            ovrn_reg <= 1'b1;
         else if (c1_reg[`SSA_C1_RXRS])
            ovrn_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_reg  <= SSA_HUNT;
         win_reg <= `SSA_ZERO8;
         cnt_reg <= 3'h0;
      end
      else if (c1_reg[`SSA_C1_RXRS] || c1_reg[`SSA_C1_CLRSYNC])
      begin
         st_reg  <= SSA_HUNT;
         cnt_reg <= 3'h0;
      end
      else if (bit_evt && rx_run)
      begin
         win_reg <= win_next;
         case (st_reg)
            SSA_HUNT:
            begin
               if (match)
               begin
                  st_reg  <= SSA_SYNC;
                  cnt_reg <= 3'h0;
               end
            end
            SSA_SYNC: cnt_reg <= cnt_reg + 3'h1;
            default:  st_reg  <= SSA_HUNT;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ld_pend_reg <= 1'b0;
         ld_tgl_reg  <= 1'b0;
         hold_reg    <= `SSA_ZERO8;
      end
      else if (ld_start)
      begin
         ld_pend_reg <= 1'b1;
         ld_tgl_reg  <= ~ld_tgl_reg;
         hold_reg    <= tx_head;
      end
      else if (ack_evt)
      begin
         ld_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_out <= `SSA_ZERO8;
         irq_out   <= 1'b0;
      end
      else
      begin
         irq_out <= (c1_reg[`SSA_C1_RIE] && (rx_byte_available || ovrn_reg || dcd_flag_reg))
                    || (c1_reg[`SSA_C1_TIE] && (tx_slot_available || tuf_reg || cts_flag_reg));
         if (rd0)
            rdata_out <= stat;
         else if (rd1)
            rdata_out <= rx_byte_available ? rx_head : `SSA_ZERO8;
      end
   end

   sequence s_wr0;
      wr0;
   endsequence
   sequence s_rd1_full;
      rd1 && rx_byte_available;
   endsequence
   property p_dcd_latch;
      @(posedge mclk_in) disable iff (!rst_n_in) dcd_rise |=> dcd_flag_reg;
   endproperty
   a_dcd_latch: assert property (p_dcd_latch) else $error("carrier edge not latched");
   property p_rx_inhibit;
      @(posedge mclk_in) disable iff (!rst_n_in) dcd_flag_reg |-> !rx_push;
   endproperty
   a_rx_inhibit: assert property (p_rx_inhibit) else $error("receiver ran after carrier loss");
   property p_cts_latch;
      @(posedge mclk_in) disable iff (!rst_n_in) cts_rise |=> cts_flag_reg && !ld_start;
   endproperty
   a_cts_latch: assert property (p_cts_latch) else $error("clear-to-send edge not acted on");
   property p_tx_slot_available_ext;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (cts_flag_reg && c3_reg[`SSA_C3_EXTSYNC] && !c1_reg[`SSA_C1_TXRS]) |-> (stat[1] == tx_ready);
   endproperty
   a_tx_slot_available_ext: assert property (p_tx_slot_available_ext) else $error("slot flag changed in external sync");
   property p_stat_read;
      @(posedge mclk_in) disable iff (!rst_n_in) rd0 |=> (rdata_out == $past(stat));
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");
   property p_c1_write;
      @(posedge mclk_in) disable iff (!rst_n_in) s_wr0 |=> (c1_reg == $past(wdata_in));
   endproperty
   a_c1_write: assert property (p_c1_write) else $error("primary control not written");
   property p_rx_reset;
      @(posedge mclk_in) disable iff (!rst_n_in) c1_reg[`SSA_C1_RXRS] |=> !rx_byte_available && (st_reg == SSA_HUNT);
   endproperty
   a_rx_reset: assert property (p_rx_reset) else $error("receiver reset ineffective");
   property p_data_read;
      @(posedge mclk_in) disable iff (!rst_n_in) s_rd1_full |=> (rdata_out == $past(rx_head));
   endproperty
   a_data_read: assert property (p_data_read) else $error("receive byte read wrong");
   property p_tx_select;
      @(posedge mclk_in) disable iff (!rst_n_in) (wr1 && (c1_reg[7:6] != `SSA_SEL_TXF)) |-> !tx_push;
   endproperty
   a_tx_select: assert property (p_tx_select) else $error("transmit FIFO written off select");
   property p_pop;
      @(posedge mclk_in) disable iff (!rst_n_in) s_rd1_full |-> rx_pop;
   endproperty
   a_pop: assert property (p_pop) else $error("read did not remove byte");
endmodule : ssa_top
`default_nettype wire

// ---- test/ssa_modem.sv ----
// Modem model: receive and transmit bit clocks, serial receive data, capture of transmitted bits.
// Assumes the bench calls its tasks; both bit clocks stand still low between frames.
`timescale 1ns/1ps
`default_nettype none
module ssa_modem
(
   output logic      rx_clk_out,
   output logic      tx_clk_out,
   output logic      rx_data_out,
   input  wire logic tx_data_in
);
   initial
   begin
      rx_clk_out  = 1'b0;
      tx_clk_out  = 1'b0;
      rx_data_out = 1'b1;
   end

   // Bits leave least significant first and change only while the clock is low.
   task automatic send_byte(input logic [7:0] b);
      // The odd offset keeps the bit clock out of step with the system clock.
      #13;
      for (int i = 0; i < 8; i++)
      begin
         rx_data_out = b[i];
         #80 rx_clk_out = 1'b1;
         #80 rx_clk_out = 1'b0;
      end
      // A released line shows the inverse of the last bit, so a held copy is never mistaken for data.
      rx_data_out = ~b[7];
   endtask : send_byte

   // Runs the transmit clock for a burst; the first low bit after idle ones starts a byte.
   task automatic capture(output logic got, output logic [7:0] b);
      int k;
      k   = 0;
      got = 1'b0;
      b   = 8'hff;
      #13;
      for (int i = 0; i < 40; i++)
      begin
         #80 tx_clk_out = 1'b1;
         #80 tx_clk_out = 1'b0;
         if (got && k < 8)
         begin
            b[k] = tx_data_in;
            k++;
         end
         else if (!got && tx_data_in === 1'b0)
         begin
            got  = 1'b1;
            b[0] = 1'b0;
            k    = 1;
         end
      end
   endtask : capture
endmodule : ssa_modem
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the serial adapter top against a queue model of the receive path.
// Assumes the modem model drives the bit clocks and the bench drives the bus and the modem lines.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       mclk_in;
   logic       rst_n_in;
   logic       cs_in;
   logic       rw_in;
   logic       addr_in;
   logic [7:0] wdata_in;
   logic [7:0] rdata_out;
   logic       irq_out;
   logic       rx_clk;
   logic       tx_clk;
   logic       ser_in;
   logic       ser_out;
   logic       dcd_in;
   logic       cts_in;
   logic [7:0] rd;
   logic [7:0] t;
   logic       got;
   logic [7:0] rxq[$];
   int         err_total;
   int         tests_run;
   int         cycles;

   ssa_top i_dut (
      .mclk_in         (mclk_in),
      .rst_n_in        (rst_n_in),
      .cs_in           (cs_in),
      .rw_in           (rw_in),
      .addr_in         (addr_in),
      .wdata_in        (wdata_in),
      .rdata_out       (rdata_out),
      .irq_out         (irq_out),
      .rx_bit_clock_in (rx_clk),
      .tx_bit_clock_in (tx_clk),
      .serial_in       (ser_in),
      .serial_out      (ser_out),
      .dcd_in          (dcd_in),
      .cts_in          (cts_in)
   );

   ssa_modem i_modem (
      .rx_clk_out  (rx_clk),
      .tx_clk_out  (tx_clk),
      .rx_data_out (ser_in),
      .tx_data_in  (ser_out)
   );

   always #2 mclk_in = ~mclk_in;

   task automatic print_verdict();
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         err_total++;
         print_verdict();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // One access: strobe for one cycle, read data taken one cycle later.
   task automatic bus(input logic rw, input logic a, input logic [7:0] d);
      @(negedge mclk_in);
      cs_in    = 1'b1;
      rw_in    = rw;
      addr_in  = a;
      wdata_in = d;
      @(negedge mclk_in);
      cs_in = 1'b0;
      @(negedge mclk_in);
      rd = rdata_out;
   endtask : bus

   task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
      bus(1'b1, 1'b0, 8'h00);
      check(rd & mask, exp);
   endtask : stat

   // The queue holds three bytes; anything beyond is the overrun case.
   task automatic send(input logic [7:0] b, input bit keep);
      i_modem.send_byte(b);
      if (keep && rxq.size() < 3)
         rxq.push_back(b);
      repeat (30) @(negedge mclk_in);
   endtask : send

   task automatic drain(input int n);
      for (int i = 0; i < n; i++)
      begin
         bus(1'b1, 1'b1, 8'h00);
         check(rd, (rxq.size() > 0) ? rxq.pop_front() : 8'h00);
      end
   endtask : drain

   initial
   begin
      mclk_in   = 1'b0;
      rst_n_in  = 1'b0;
      cs_in     = 1'b0;
      rw_in     = 1'b1;
      addr_in   = 1'b0;
      wdata_in  = 8'h00;
      dcd_in    = 1'b0;
      cts_in    = 1'b0;
      err_total = 0;
      tests_run = 0;
      cycles    = 0;
      void'($urandom(27328));
      repeat (20) @(negedge mclk_in);
      rst_n_in = 1'b1;
      stat(8'hff, 8'h00);
      bus(1'b0, 1'b0, 8'h83);
      bus(1'b0, 1'b1, 8'h7e);
      send(8'h7e, 0);
      send(8'h5a, 0);
      stat(8'h01, 8'h00);
      bus(1'b0, 1'b0, 8'h80);
      send(8'h7e, 0);
      for (int i = 0; i < 4; i++)
         send(8'($urandom), 1);
      stat(8'he5, 8'h21);
      drain(3);
      stat(8'h01, 8'h00);
      drain(1);
      bus(1'b0, 1'b0, 8'h81);
      bus(1'b0, 1'b0, 8'h84);
      // A byte of marks flushes stale bits from the hunt window, so no false sync match can occur.
      send(8'hff, 0);
      send(8'h7e, 0);
      send(8'($urandom % 126), 1);
      send(8'h7e, 0);
      send(8'($urandom % 126), 1);
      bus(1'b0, 1'b0, 8'ha4);
      repeat (3) @(negedge mclk_in);
      check({7'h00, irq_out}, 8'h01);
      stat(8'h80, 8'h80);
      dcd_in = 1'b1;
      repeat (8) @(negedge mclk_in);
      stat(8'h05, 8'h05);
      send(8'h7e, 0);
      send(8'h3c, 0);
      drain(3);
      stat(8'h01, 8'h00);
      bus(1'b0, 1'b0, 8'h41);
      bus(1'b0, 1'b1, 8'h01);
      bus(1'b0, 1'b0, 8'hc1);
      t = 8'($urandom) & 8'hfe;
      bus(1'b0, 1'b1, t);
      i_modem.capture(got, rd);
      check(rd, t);
      @(negedge mclk_in);
      cts_in = 1'b1;
      repeat (8) @(negedge mclk_in);
      stat(8'h0a, 8'h0a);
      bus(1'b0, 1'b1, 8'($urandom) & 8'hfe);
      i_modem.capture(got, rd);
      check({7'h00, got}, 8'h00);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
